// file: shared/urx_pkg.sv
package urx_pkg;
  localparam int unsigned TICKS_PER_BIT = 16;
  localparam logic [3:0] START_SAMPLE = 4'h7;
  localparam logic [3:0] BIT_LAST = 4'hF;
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] CAP_FIFO = 5'h10;
  localparam logic [CNT_W-1:0] CAP_SINGLE = 5'h01;
  localparam int unsigned WLEN_BASE = 5;
  localparam logic [2:0] LAST_IDX_BASE = 3'h4;
  localparam int unsigned TO_WORDS = 4;
  localparam int unsigned TO_EXTRA_BITS = 12;
  localparam int unsigned FRAME_OVERHEAD = 2;
  localparam int unsigned XOFF_DELAY_CHARS = 2;
  localparam int unsigned TMR_W = 10;
  localparam int unsigned NUM_FC_CHARS = 4;
  localparam logic [7:0] CHAR_RESET = 8'h00;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [1:0] WLEN_MAX = 2'h3;
  localparam logic [1:0] CH_XON1 = 2'h0;
  localparam logic [1:0] CH_XON2 = 2'h1;
  localparam logic [1:0] CH_XOFF1 = 2'h2;
  localparam logic [1:0] CH_XOFF2 = 2'h3;
  localparam logic [1:0] SWFC_OFF = 2'h0;
  localparam logic [1:0] SWFC_SINGLE1 = 2'h1;
  localparam logic [1:0] SWFC_SINGLE2 = 2'h2;
  localparam logic [1:0] SWFC_DOUBLE = 2'h3;

  typedef struct packed {
    logic [1:0] wlen;       // line_control_reg[1:0]
    logic par_en;
    logic par_even;
    logic fifo_en;          // buffer_control_reg[0]
    logic [1:0] trig_sel;   // 0..3 = 1,4,8,14
    logic ie_rx;            // interrupt_enable_reg[0]
    logic ie_xoff;          // interrupt_enable_reg[5]
    logic ie_rts;           // interrupt_enable_reg[6]
    logic ie_cts;           // interrupt_enable_reg[7]
    logic efr_enh;          // enhanced_function_reg[4]
    logic efr_special;      // enhanced_function_reg[5]
    logic efr_auto_rts;     // enhanced_function_reg[6]
    logic efr_auto_cts;     // enhanced_function_reg[7]
    logic [1:0] swfc_rx;    // receive flow char mode
    logic auto_xoff_tx;     // send stop/resume chars
    logic mcr_rts;          // modem_control_reg[1]
    logic mcr_ir;           // modem_control_reg[6]
  } urx_cfg_t;

  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
    logic [7:0] data;
  } urx_entry_t;

  function automatic logic [CNT_W-1:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0: trig_level = 5'h01;
      2'h1: trig_level = 5'h04;
      2'h2: trig_level = 5'h08;
      default: trig_level = 5'h0E;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] resume_level(input logic [1:0] sel);
    case (sel)
      2'h0: resume_level = 5'h00;
      2'h1: resume_level = 5'h01;
      2'h2: resume_level = 5'h04;
      default: resume_level = 5'h08;
    endcase
  endfunction

  function automatic logic char_match(input logic [7:0] a, input logic [7:0] b, input logic [1:0] wlen);
    logic [7:0] mask;
    mask = MASK_FULL >> (WLEN_MAX - wlen);
    char_match = ((a ^ b) & mask) == CHAR_RESET;
  endfunction

  function automatic logic [TMR_W-1:0] to_limit(input logic [1:0] wlen);
    to_limit = TMR_W'((TO_WORDS * (WLEN_BASE + wlen) + TO_EXTRA_BITS) * TICKS_PER_BIT);
  endfunction

  function automatic logic [TMR_W-1:0] xoff_limit(input logic [1:0] wlen, input logic par);
    xoff_limit = TMR_W'(XOFF_DELAY_CHARS * (WLEN_BASE + wlen + par + FRAME_OVERHEAD) * TICKS_PER_BIT);
  endfunction
endpackage

// file: sim/urx_remote.sv
`timescale 1ns/10ps
module urx_remote (
  input wire logic sys_clk_i, // system clock
  input wire logic tick_i,    // 16x strobe
  output logic rx_o           // line into the receiver
);
  initial rx_o = 1'b1;
  // one bit time is sixteen strobes
  task automatic hold_bit(input logic b);
    for (int t = 0; t < 16; t++) begin
      @(posedge sys_clk_i iff tick_i);
      rx_o <= b;
    end
  endtask
  task automatic send(input logic [11:0] frame, input int len);
    hold_bit(1'b0);
    for (int i = 0; i < len; i++) begin
      hold_bit(frame[i]); // lsb first
    end
    hold_bit(1'b1);
  endtask
  // low for fewer ticks than half a bit
  task automatic glitch(input int n);
    for (int t = 0; t < n; t++) begin
      @(posedge sys_clk_i iff tick_i);
      rx_o <= 1'b0;
    end
    hold_bit(1'b1);
  endtask
  // light off: the infrared line idles low
  task automatic ir_dark;
    rx_o <= 1'b0;
  endtask
  // light pulse of three strobes for a zero bit, dark for a one
  task automatic ir_send(input logic [11:0] frame, input int len);
    logic [12:0] bits;
    bits = {frame, 1'b0};
    for (int i = 0; i <= len; i++) begin
      for (int t = 0; t < 16; t++) begin
        @(posedge sys_clk_i iff tick_i);
        rx_o <= !bits[i] && (t < 3);
      end
    end
    hold_bit(1'b0);
  endtask
endmodule

// file: sim/urx_top_tb.sv
`timescale 1ns/10ps
module urx_top_tb;
  import urx_pkg::*;
  typedef struct {
    logic [1:0] wlen;
    logic par_en;
    logic [11:0] frame;
    int len;
    logic [7:0] exp_data;
    logic [2:0] exp_err;
  } urx_row_t;
  urx_row_t rows [5] = '{'{2'h3, 1'b0, 12'h1A5, 9, 8'hA5, 3'h0}, '{2'h0, 1'b0, 12'h035, 6, 8'h15, 3'h0},
    '{2'h3, 1'b1, 12'h303, 10, 8'h03, 3'h1}, '{2'h3, 1'b0, 12'h05A, 9, 8'h5A, 3'h2},
    '{2'h3, 1'b1, 12'h000, 10, 8'h00, 3'h6}};
  logic sys_clk_i = 1'b0;
  logic rst_n_i, tick_16x_i, rx_pin_i, cts_n_i, rhr_rd_i, isr_rd_i, char_wr_i, tx_bit_i, xon_seen;
  urx_cfg_t cfg_i;
  logic [1:0] char_sel_i;
  logic [7:0] char_data_i, rhr_data_o;
  logic [3:0] tx_phase_i;
  logic [2:0] line_err_o;
  logic data_ready_o, timeout_o, special_o, flow_evt_o, int_o, rts_n_o, tx_halt_o, send_xoff_o, send_xon_o;
  logic tx_line_o;
  int err_count = 0;
  int comparisons = 0;
  int n;
  urx_top urx_top_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .tick_16x_i(tick_16x_i), .cfg_i(cfg_i),
    .rx_pin_i(rx_pin_i), .cts_n_i(cts_n_i), .rhr_rd_i(rhr_rd_i), .isr_rd_i(isr_rd_i), .char_wr_i(char_wr_i),
    .char_sel_i(char_sel_i), .char_data_i(char_data_i), .tx_bit_i(tx_bit_i), .tx_phase_i(tx_phase_i),
    .rhr_data_o(rhr_data_o), .line_err_o(line_err_o), .data_ready_o(data_ready_o), .timeout_o(timeout_o),
    .special_o(special_o), .flow_evt_o(flow_evt_o), .int_o(int_o), .rts_n_o(rts_n_o), .tx_halt_o(tx_halt_o),
    .send_xoff_o(send_xoff_o), .send_xon_o(send_xon_o), .tx_line_o(tx_line_o));
  urx_remote urx_remote_inst (.sys_clk_i(sys_clk_i), .tick_i(tick_16x_i), .rx_o(rx_pin_i));
  always #5 sys_clk_i = ~sys_clk_i;
  // strobe every other cycle, bit time 32 cycles
  always @(posedge sys_clk_i) tick_16x_i <= ~tick_16x_i;
  always @(posedge sys_clk_i) if (send_xon_o === 1'b1) xon_seen <= 1'b1;
  task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask
  task automatic pop;
    rhr_rd_i <= 1'b1;
    cyc(1);
    rhr_rd_i <= 1'b0;
    cyc(3);
  endtask
  task automatic isr_read;
    isr_rd_i <= 1'b1;
    cyc(1);
    isr_rd_i <= 1'b0;
    cyc(3);
  endtask
  task automatic wr_char(input logic [1:0] sel, input logic [7:0] d);
    char_wr_i <= 1'b1;
    char_sel_i <= sel;
    char_data_i <= d;
    cyc(1);
    char_wr_i <= 1'b0;
    cyc(1);
  endtask
  task automatic send8(input logic [7:0] d);
    urx_remote_inst.send({4'h0, 1'b1, d}, 9);
    cyc(4);
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 400 && data_ready_o !== 1'b1; i++) cyc(1);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #500000;
    err_count++;
    wrap_up();
  end
  initial begin
    {rst_n_i, tick_16x_i, rhr_rd_i, isr_rd_i, char_wr_i, cts_n_i, xon_seen} = '0;
    {cfg_i, char_sel_i, char_data_i, tx_phase_i} = '0;
    tx_bit_i = 1'b1;
    cyc(12);
    check("reset outs", {data_ready_o, timeout_o, special_o, flow_evt_o, int_o, rts_n_o, tx_halt_o,
      tx_line_o, line_err_o}, 11'h028);
    rst_n_i <= 1'b1;
    cyc(4);
    foreach (rows[k]) begin
      cfg_i.wlen <= rows[k].wlen;
      cfg_i.par_en <= rows[k].par_en;
      cfg_i.par_even <= rows[k].par_en;
      cyc(2);
      urx_remote_inst.send(rows[k].frame, rows[k].len);
      wait_ready();
      check("row data", 11'(rhr_data_o), 11'(rows[k].exp_data));
      check("row tags", 11'(line_err_o), 11'(rows[k].exp_err));
      pop();
      check("row empty", 11'(data_ready_o), 11'h0);
    end
    {cfg_i.par_en, cfg_i.par_even} <= 2'h0;
    urx_remote_inst.glitch(4);
    cyc(40);
    check("false start", 11'(data_ready_o), 11'h0);
    {cfg_i.fifo_en, cfg_i.efr_auto_rts, cfg_i.mcr_rts, cfg_i.efr_enh, cfg_i.ie_rts, cfg_i.auto_xoff_tx} <= '1;
    cfg_i.trig_sel <= 2'h3;
    cyc(3);
    check("rts start", 11'(rts_n_o), 11'h0);
    for (int i = 0; i < 14; i++) urx_remote_inst.send({4'h0, 1'b1, 8'(8'h40 + i)}, 9);
    for (n = 0; n < 700 && send_xoff_o !== 1'b1; n++) cyc(1);
    check("xoff delay", 11'(n >= 560 && n <= 620), 11'h1);
    check("rts off", {8'h0, rts_n_o, flow_evt_o, int_o}, 11'h7);
    for (int i = 14; i < 17; i++) send8(8'(8'h40 + i));
    isr_read();
    check("evt clear", 11'(flow_evt_o), 11'h0);
    for (int i = 0; i < 16; i++) begin
      check("fifo order", 11'(rhr_data_o), 11'(8'h40 + i));
      pop();
      if (i == 6) check("xon early", 11'(xon_seen), 11'h0);
    end
    check("xon sent", {9'h0, xon_seen, rts_n_o}, 11'h2);
    check("overflow drop", 11'(data_ready_o), 11'h0);
    cfg_i.ie_rx <= 1'b1;
    send8(8'h77);
    cyc(1300);
    check("timeout early", 11'(timeout_o), 11'h0);
    cyc(200);
    check("timeout", {9'h0, timeout_o, int_o}, 11'h3);
    pop();
    check("timeout gone", 11'(timeout_o), 11'h0);
    {cfg_i.ie_rx, cfg_i.ie_xoff} <= 2'h1;
    cfg_i.swfc_rx <= SWFC_SINGLE1;
    send8(8'h00);
    check("reset char halt", {8'h0, tx_halt_o, special_o, data_ready_o}, 11'h6);
    wr_char(CH_XOFF1, 8'hF3);
    wr_char(CH_XON1, 8'h11);
    cfg_i.wlen <= 2'h0;
    urx_remote_inst.send(12'h031, 6);
    cyc(4);
    check("resume", {9'h0, tx_halt_o, special_o}, 11'h0);
    urx_remote_inst.send(12'h033, 6);
    cyc(4);
    check("short halt", {9'h0, tx_halt_o, int_o}, 11'h3);
    urx_remote_inst.send(12'h031, 6);
    wr_char(CH_XOFF2, 8'h93);
    wr_char(CH_XON2, 8'h91);
    cfg_i.wlen <= 2'h3;
    cfg_i.swfc_rx <= SWFC_DOUBLE;
    send8(8'hF3);
    send8(8'h41);
    check("pair broken", {8'h0, tx_halt_o, rhr_data_o == 8'h41, data_ready_o}, 11'h3);
    pop();
    send8(8'hF3);
    send8(8'h93);
    check("pair halt", {9'h0, tx_halt_o, data_ready_o}, 11'h2);
    send8(8'h11);
    send8(8'h91);
    check("pair resume", 11'(tx_halt_o), 11'h0);
    cfg_i.swfc_rx <= SWFC_OFF;
    cfg_i.efr_special <= 1'b1;
    send8(8'h93);
    wait_ready();
    check("special", {2'h0, special_o, rhr_data_o}, 11'h193);
    pop();
    isr_read();
    {cfg_i.efr_auto_cts, cfg_i.ie_cts} <= 2'h3;
    cts_n_i <= 1'b1;
    cyc(8);
    check("cts stop", {9'h0, tx_halt_o, flow_evt_o}, 11'h3);
    cts_n_i <= 1'b0;
    cyc(8);
    check("cts go", 11'(tx_halt_o), 11'h0);
    {cfg_i.fifo_en, cfg_i.ie_rx} <= 2'h1;
    isr_read();
    check("no int", 11'(int_o), 11'h0);
    send8(8'h21);
    send8(8'h22);
    check("single slot", {2'h0, int_o, rhr_data_o}, 11'h121);
    pop();
    cfg_i.mcr_ir <= 1'b1;
    urx_remote_inst.ir_dark();
    cyc(3);
    check("ir idle", 11'(tx_line_o), 11'h0);
    tx_bit_i <= 1'b0;
    for (int p = 0; p < 16; p++) begin
      tx_phase_i <= 4'(p);
      cyc(3);
      check("ir pulse", 11'(tx_line_o), 11'(p < 3));
    end
    // drop whatever the switch into infrared mode assembled
    wait_ready();
    pop();
    urx_remote_inst.ir_send(12'h1A5, 9);
    wait_ready();
    check("ir receive", {line_err_o, rhr_data_o}, 11'h0A5);
    wrap_up();
  end
endmodule

// file: src/urx_fifo.sv
`timescale 1ns/10ps
module urx_fifo
  import urx_pkg::*;
(
  input wire logic sys_clk_i,              // system clock
  input wire logic rst_n_i,                // sync reset, active low
  input wire logic wr_i,                   // push one entry
  input wire urx_entry_t wr_data_i,        // entry pushed
  input wire logic rd_i,                   // pop head
  input wire logic [CNT_W-1:0] cap_i,      // usable entries
  output urx_entry_t head_o,               // oldest entry
  output logic [CNT_W-1:0] count_o         // fill level
);
  urx_entry_t mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  wire do_rd = rd_i && (count_o != '0);
  // full buffer still accepts when a pop frees a slot in the same cycle
  wire do_wr = wr_i && ((count_o < cap_i) || do_rd);

  assign head_o = mem[rd_ptr];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count_o <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + PTR_W'(1);
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + PTR_W'(1);
      end
      count_o <= count_o + CNT_W'(do_wr) - CNT_W'(do_rd);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data_i;
    end
  end
endmodule

// file: src/urx_top.sv
`timescale 1ns/10ps
module urx_top
  import urx_pkg::*;
(
  input wire logic sys_clk_i,              // system clock
  input wire logic rst_n_i,                // sync reset, active low
  input wire logic tick_16x_i,             // 16x baud strobe
  input wire urx_cfg_t cfg_i,              // control bits
  input wire logic rx_pin_i,               // serial receive pin
  input wire logic cts_n_i,                // clear-to-send pin
  input wire logic rhr_rd_i,               // host reads holding reg
  input wire logic isr_rd_i,               // host reads interrupt status
  input wire logic char_wr_i,              // write a flow character
  input wire logic [1:0] char_sel_i,       // which flow character
  input wire logic [7:0] char_data_i,      // flow character value
  input wire logic tx_bit_i,               // transmitter serial bit
  input wire logic [3:0] tx_phase_i,       // tick within tx bit
  output logic [7:0] rhr_data_o,           // head data byte
  output logic [2:0] line_err_o,           // head tags: brk,frm,par
  output logic data_ready_o,               // buffer not empty
  output logic timeout_o,                  // receive timeout flag
  output logic special_o,                  // status bit 4
  output logic flow_evt_o,                 // status bit 5
  output logic int_o,                      // interrupt request
  output logic rts_n_o,                    // request-to-send pin
  output logic tx_halt_o,                  // hold transmitter
  output logic send_xoff_o,                // send stop chars pulse
  output logic send_xon_o,                 // send resume chars pulse
  output logic tx_line_o                   // transmit pin
);
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} urx_state_t;

  urx_state_t state;
  logic rx_s1;
  logic rx_s2;
  logic rx_d;
  logic cts_s1;
  logic cts_s2;
  logic cts_d;
  logic ir_busy;
  logic [3:0] ir_cnt;
  logic [3:0] tick_cnt;
  logic [2:0] bit_idx;
  logic [7:0] shreg;
  logic par_acc;
  logic par_bad;
  logic par_bit;
  logic [7:0] fc_char [NUM_FC_CHARS];
  logic pend_on;
  logic pend_off;
  logic xoff_halt;
  logic [TMR_W-1:0] to_cnt;
  logic [TMR_W-1:0] dly_cnt;
  logic xoff_sent;
  logic rts_off;
  urx_entry_t head;
  logic [CNT_W-1:0] count;

  // receive front end
  wire ir_start = cfg_i.mcr_ir && rx_s2 && !ir_busy;
  wire rx_bit = cfg_i.mcr_ir ? !ir_busy : rx_s2;
  wire falling = rx_d && !rx_bit;
  wire [3:0] sample_at = (state == ST_START) ? START_SAMPLE : BIT_LAST;
  wire sample = tick_16x_i && (tick_cnt == sample_at);
  wire [2:0] last_idx = LAST_IDX_BASE + {1'b0, cfg_i.wlen};
  wire char_done = (state == ST_STOP) && sample;
  urx_entry_t rx_entry;
  assign rx_entry = '{brk: !rx_bit && (shreg == CHAR_RESET) && !par_bit, frm: !rx_bit, par: par_bad, data: shreg};

  // flow character comparison
  wire xon1_m = char_match(shreg, fc_char[CH_XON1], cfg_i.wlen);
  wire xon2_m = char_match(shreg, fc_char[CH_XON2], cfg_i.wlen);
  wire xoff1_m = char_match(shreg, fc_char[CH_XOFF1], cfg_i.wlen);
  wire xoff2_m = char_match(shreg, fc_char[CH_XOFF2], cfg_i.wlen);
  wire single = (cfg_i.swfc_rx == SWFC_SINGLE1) || (cfg_i.swfc_rx == SWFC_SINGLE2);
  wire dbl = cfg_i.swfc_rx == SWFC_DOUBLE;
  wire sel_on = (cfg_i.swfc_rx == SWFC_SINGLE2) ? xon2_m : xon1_m;
  wire sel_off = (cfg_i.swfc_rx == SWFC_SINGLE2) ? xoff2_m : xoff1_m;
  wire on_pair = dbl && pend_on && xon2_m;
  wire off_pair = dbl && pend_off && xoff2_m;
  wire on_evt = char_done && ((single && sel_on) || on_pair);
  wire off_evt = char_done && ((single && sel_off) || off_pair);
  wire consume = char_done && ((single && (sel_on || sel_off)) || (dbl && (xon1_m || xoff1_m || on_pair || off_pair)));
  wire store = char_done && !consume;
  wire special_hit = store && cfg_i.efr_special && xoff2_m;

  // buffer levels
  wire [CNT_W-1:0] trig = trig_level(cfg_i.trig_sel);
  wire [CNT_W-1:0] res_lvl = resume_level(cfg_i.trig_sel);
  wire nonempty = count != '0;
  wire over_trig = count >= trig;
  wire at_resume = count <= res_lvl;
  wire rx_lvl = cfg_i.fifo_en ? over_trig : nonempty;
  wire [CNT_W-1:0] cap = cfg_i.fifo_en ? CAP_FIFO : CAP_SINGLE;

  // flags and pins
  wire to_hit = tick_16x_i && nonempty && (to_cnt == to_limit(cfg_i.wlen) - TMR_W'(1));
  wire to_rst = !nonempty || char_done || rhr_rd_i;
  wire next_rts_n = !(cfg_i.mcr_rts && !(cfg_i.efr_auto_rts && rts_off));
  wire rts_rise = next_rts_n && !rts_n_o;
  wire cts_rise = cts_s2 && !cts_d;
  wire isr5_set = cfg_i.efr_enh && ((cfg_i.ie_rts && rts_rise) || (cfg_i.ie_cts && cts_rise));
  wire isr4_set = (off_evt && cfg_i.ie_xoff) || special_hit;
  wire next_xoff_halt = off_evt || (xoff_halt && !on_evt);
  wire dly_done = dly_cnt == xoff_limit(cfg_i.wlen, cfg_i.par_en);
  wire ir_pulse = !tx_bit_i && (tx_phase_i < IR_PULSE_TICKS);
  wire next_tx_line = cfg_i.mcr_ir ? ir_pulse : tx_bit_i;
  wire next_int = (cfg_i.ie_rx && (rx_lvl || timeout_o)) || (special_o && cfg_i.ie_xoff) || flow_evt_o;

  urx_fifo u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(store),
    .wr_data_i(rx_entry),
    .rd_i(rhr_rd_i),
    .cap_i(cap),
    .head_o(head),
    .count_o(count)
  );

  for (genvar i = 0; i < NUM_FC_CHARS; i++) begin : g_fc
    always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
        fc_char[i] <= CHAR_RESET;
      end else if (char_wr_i && (char_sel_i == 2'(i))) begin
        fc_char[i] <= char_data_i;
      end
    end
  end

  // pin synchronisers; receive idles low for the infrared decoder
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rx_s1 <= 1'b0;
      rx_s2 <= 1'b0;
      // matches the synchroniser so no false fall follows reset
      rx_d <= 1'b0;
      cts_s1 <= 1'b1;
      cts_s2 <= 1'b1;
      cts_d <= 1'b1;
    end else begin
      rx_s1 <= rx_pin_i;
      rx_s2 <= rx_s1;
      rx_d <= rx_bit;
      cts_s1 <= cts_n_i;
      cts_s2 <= cts_s1;
      cts_d <= cts_s2;
    end
  end

  // stretch each light pulse to a whole zero bit
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ir_busy <= 1'b0;
      ir_cnt <= 4'h0;
    end else if (ir_start) begin
      ir_busy <= 1'b1;
      ir_cnt <= 4'h0;
    end else if (ir_busy && tick_16x_i) begin
      ir_cnt <= ir_cnt + 4'h1;
      if (ir_cnt == BIT_LAST) begin
        ir_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      tick_cnt <= 4'h0;
      bit_idx <= 3'h0;
      shreg <= CHAR_RESET;
      par_acc <= 1'b0;
      par_bad <= 1'b0;
      par_bit <= 1'b0;
    end else begin
      if (tick_16x_i) begin
        tick_cnt <= sample ? 4'h0 : tick_cnt + 4'h1;
      end
      case (state)
        ST_IDLE: if (falling) begin
          state <= ST_START;
          tick_cnt <= 4'h0;
          bit_idx <= 3'h0;
          shreg <= CHAR_RESET;
          par_acc <= 1'b0;
          par_bad <= 1'b0;
          par_bit <= 1'b0;
        end
        ST_START: if (sample) begin
          state <= rx_bit ? ST_IDLE : ST_DATA;
        end
        ST_DATA: if (sample) begin
          shreg[bit_idx] <= rx_bit;
          par_acc <= par_acc ^ rx_bit;
          bit_idx <= bit_idx + 3'h1;
          if (bit_idx == last_idx) begin
            state <= cfg_i.par_en ? ST_PAR : ST_STOP;
          end
        end
        ST_PAR: if (sample) begin
          par_bit <= rx_bit;
          par_bad <= !(par_acc ^ rx_bit ^ cfg_i.par_even);
          state <= ST_STOP;
        end
        ST_STOP: if (sample) begin
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // software flow tracking; set beats clear on every flag but pend_on and pend_off
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pend_on <= 1'b0;
      pend_off <= 1'b0;
      xoff_halt <= 1'b0;
      special_o <= 1'b0;
      flow_evt_o <= 1'b0;
    end else begin
      if (char_done) begin
        pend_on <= dbl && xon1_m && !on_pair;
        pend_off <= dbl && xoff1_m && !off_pair;
      end
      xoff_halt <= next_xoff_halt;
      special_o <= isr4_set || (special_o && !on_evt && !isr_rd_i);
      flow_evt_o <= isr5_set || (flow_evt_o && !isr_rd_i);
    end
  end

  // receive timeout and automatic stop/resume sending
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      to_cnt <= '0;
      timeout_o <= 1'b0;
      dly_cnt <= '0;
      xoff_sent <= 1'b0;
      send_xoff_o <= 1'b0;
      send_xon_o <= 1'b0;
      rts_off <= 1'b0;
    end else begin
      to_cnt <= to_rst ? '0 : (tick_16x_i ? to_cnt + TMR_W'(1) : to_cnt);
      timeout_o <= to_hit || (timeout_o && !rhr_rd_i && nonempty);
      send_xoff_o <= 1'b0;
      send_xon_o <= 1'b0;
      rts_off <= over_trig || (rts_off && !at_resume);
      if (!cfg_i.auto_xoff_tx || !over_trig || xoff_sent) begin
        dly_cnt <= '0;
      end else if (dly_done) begin
        send_xoff_o <= 1'b1;
        xoff_sent <= 1'b1;
      end else if (tick_16x_i) begin
        dly_cnt <= dly_cnt + TMR_W'(1);
      end
      if (xoff_sent && at_resume) begin
        send_xon_o <= 1'b1;
        xoff_sent <= 1'b0;
      end
    end
  end

  // registered host view and pins
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rhr_data_o <= CHAR_RESET;
      line_err_o <= 3'h0;
      data_ready_o <= 1'b0;
      int_o <= 1'b0;
      rts_n_o <= 1'b1;
      tx_halt_o <= 1'b0;
      tx_line_o <= 1'b1;
    end else begin
      rhr_data_o <= head.data;
      line_err_o <= nonempty ? {head.brk, head.frm, head.par} : 3'h0;
      data_ready_o <= nonempty;
      int_o <= next_int;
      rts_n_o <= next_rts_n;
      tx_halt_o <= (cfg_i.efr_auto_cts && cts_s2) || xoff_halt;
      tx_line_o <= next_tx_line;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_false_start: assert property ((state == ST_START) && sample && rx_bit |=> state == ST_IDLE)
    else $error("false start not discarded");
  chk_mid_bit: assert property ((state == ST_DATA) && tick_16x_i && !sample |=> $stable(bit_idx))
    else $error("data bit taken off centre");
  chk_head_tags: assert property (nonempty |=> line_err_o == $past({head.brk, head.frm, head.par}))
    else $error("status tags do not follow head");
  chk_depth: assert property (count <= CAP_FIFO)
    else $error("buffer fill beyond sixteen");
  chk_read_pop: assert property (rhr_rd_i && nonempty && !store |=> count == $past(count) - CNT_W'(1))
    else $error("read did not advance buffer");
  chk_ready_int: assert property (cfg_i.ie_rx && !cfg_i.fifo_en && nonempty |=> int_o)
    else $error("data ready interrupt missing");
  chk_timeout: assert property ($rose(timeout_o) |-> $past(to_cnt) == to_limit($past(cfg_i.wlen)) - TMR_W'(1))
    else $error("timeout raised at wrong count");
  chk_rts_start: assert property (!cfg_i.mcr_rts |=> rts_n_o)
    else $error("request-to-send active without start");
  chk_rts_evt: assert property (cfg_i.efr_enh && cfg_i.ie_rts && rts_rise |=> flow_evt_o)
    else $error("request-to-send event not flagged");
  chk_cts_halt: assert property (cfg_i.efr_auto_cts && cts_s2 |=> tx_halt_o)
    else $error("clear-to-send high did not halt");
  chk_xoff_halt: assert property (off_evt |=> xoff_halt ##1 tx_halt_o)
    else $error("stop character did not halt");
  chk_consume: assert property (consume && !rhr_rd_i |=> count == $past(count))
    else $error("flow character stored");
  chk_ir_idle: assert property (cfg_i.mcr_ir && tx_bit_i |=> !tx_line_o)
    else $error("infrared transmit not idle low");
endmodule
